// File: cmd_consts.svh
// Constants for the clock mode and internal divider block
`ifndef CMD_CONSTS_SVH
`define CMD_CONSTS_SVH

// Clock origin codes in the configuration word
`define CMD_ORG_LP 3'h0
`define CMD_ORG_XT 3'h1
`define CMD_ORG_HS 3'h2
`define CMD_ORG_EC 3'h3
`define CMD_ORG_INTIO 3'h4
`define CMD_ORG_INTOUT 3'h5
`define CMD_ORG_RESISTOR_CAPACITOR_PIN_IO_MODE 3'h6
`define CMD_ORG_RCOUT 3'h7

// Divider choice reset value and control register layout
`define CMD_SEL_RESET 2'h2
`define CMD_REG_SEL_HI 5
`define CMD_REG_SEL_LO 4
`define CMD_REG_LOCKED 3
`define CMD_REG_STABLE 2

// Oscillator rates as phase steps of the 200 MHz clock
`define CMD_FAST_INC 9'h010
`define CMD_FAST_MOD 9'h0C8
`define CMD_SLOW_INC 9'h001
`define CMD_SLOW_MOD 9'h190

// Settling times in ns and their cycle counts
`define CMD_CLK_NS 5
`define CMD_STABLE_NS 1000
`define CMD_LOCK_NS 2000
`define CMD_STABLE_CYC ((`CMD_STABLE_NS + `CMD_CLK_NS - 1) / `CMD_CLK_NS)
`define CMD_LOCK_CYC ((`CMD_LOCK_NS + `CMD_CLK_NS - 1) / `CMD_CLK_NS)

`endif

// File: cmd_pkg.sv
// Types for the clock mode and internal divider block
package cmd_pkg;

    // Operating clock modes
    typedef enum logic [2:0] {
        MODE_LOW_POWER_XTAL,
        MODE_MEDIUM_XTAL,
        MODE_HIGH_XTAL,
        MODE_OUTSIDE_CLK,
        MODE_INT_ALL_IO,
        MODE_INT_QUARTER,
        MODE_RC_PIN_IO,
        MODE_RC_QUARTER_CLOCK_OUTPUT
    } cmd_mode_t;

    // State of the phase step tick generator
    typedef struct packed {
        logic [8:0] acc;
        logic tick;
    } cmd_tick_t;

    // State of the postscaler
    typedef struct packed {
        logic [2:0] cnt;
        logic [1:0] sel;
    } cmd_post_t;

    // State of the top block
    typedef struct packed {
        logic [2:0] origin;
        logic fast;
        logic [1:0] sel;
        logic pin_d;
        logic sys_en;
        logic [1:0] qcnt;
        logic [11:0] lock_cnt;
        logic locked;
        logic stable;
        logic in_o;
        logic in_oe;
        logic out_o;
        logic out_oe;
    } cmd_core_t;

endpackage

// File: cmd_tickgen.sv
// Fractional rate tick generator standing in for an oscillator
`timescale 1ns/1ps
`default_nettype none
module cmd_tickgen #(
    parameter logic [8:0] INC = 9'h001,
    parameter logic [8:0] MOD = 9'h002
) (
    // Clock and reset
    input wire logic clk,
    input wire logic reset,
    // Tick out, one cycle at the oscillator rate
    output logic tick
);
    cmd_pkg::cmd_tick_t st_r;
    cmd_pkg::cmd_tick_t st_nxt;
    logic [9:0] sum;

    // Add the step and wrap at the modulus
    always_comb begin
        st_nxt = st_r;
        sum = {1'b0, st_r.acc} + {1'b0, INC};
        if (sum >= {1'b0, MOD}) begin
            st_nxt.acc = 9'((sum - {1'b0, MOD}));
            st_nxt.tick = 1'b1;
        end else begin
            st_nxt.acc = sum[8:0];
            st_nxt.tick = 1'b0;
        end
        if (reset) begin
            st_nxt = '0;
        end
    end

    // State register
    always_ff @(posedge clk) begin
        st_r <= st_nxt;
    end

    assign tick = st_r.tick;

    // Oscillator ticks never come back to back
    tick_spacing_a: assert property (@(posedge clk) disable iff (reset)
        tick |=> !tick) else $error("oscillator ticks back to back");
endmodule
`default_nettype wire

// File: cmd_postscale.sv
// Postscaler dividing oscillator ticks by 1, 2, 4 or 8
`timescale 1ns/1ps
`default_nettype none
`include "cmd_consts.svh"
module cmd_postscale (
    // Clock and reset
    input wire logic clk,
    input wire logic reset,
    // Oscillator tick and requested divider choice
    input wire logic tick,
    input wire logic [1:0] sel_req,
    // Divided tick and the choice in force
    output logic div_en,
    output logic [1:0] sel_used
);
    cmd_pkg::cmd_post_t st_r;
    cmd_pkg::cmd_post_t st_nxt;
    logic [2:0] lim;

    // Last count before wrap: 11 gives 0, 00 gives 7
    assign lim = 3'h7 >> st_r.sel;
    assign div_en = tick && (st_r.cnt == lim);
    assign sel_used = st_r.sel;

    // Count ticks; take a new choice only at the wrap
    always_comb begin
        st_nxt = st_r;
        if (div_en) begin
            st_nxt.cnt = 3'h0;
            st_nxt.sel = sel_req;
        end else if (tick) begin
            st_nxt.cnt = 3'(st_r.cnt + 3'h1);
        end
        if (reset) begin
            st_nxt.cnt = 3'h0;
            st_nxt.sel = `CMD_SEL_RESET;
        end
    end

    // State register
    always_ff @(posedge clk) begin
        st_r <= st_nxt;
    end

    // Ratio switches only right after a divided tick
    clean_switch_a: assert property (@(posedge clk) disable iff (reset)
        $changed(st_r.sel) |-> $past(div_en))
        else $error("ratio changed mid period");

    // Count stays inside the chosen ratio
    count_bound_a: assert property (@(posedge clk) disable iff (reset)
        st_r.cnt <= lim) else $error("postscaler count out of range");
endmodule
`default_nettype wire

// File: cmd_clock_ctrl.sv
// Clock mode decode, internal divider and clock pin control
`timescale 1ns/1ps
`default_nettype none
`include "cmd_consts.svh"
module cmd_clock_ctrl (
    // Clock and reset
    input wire logic CLK,
    input wire logic RESET,

    // Programmed configuration, sampled during reset
    input wire logic [2:0] CFG_CLK_ORIGIN,
    input wire logic CFG_FAST_RANGE,

    // Software write of the divider choice
    input wire logic FREQ_WR_EN,
    input wire logic [1:0] FREQ_WR_DATA,

    // Oscillator control register image and status
    output logic [7:0] OSC_CTRL_RD,
    output logic [2:0] CLK_MODE,

    // System clock enable, one cycle per system clock
    output logic SYS_CLK_EN,

    // Oscillator input pin
    input wire logic OSC_IN_PIN_I,
    output logic OSC_IN_PIN_O,
    output logic OSC_IN_PIN_OE,

    // Oscillator output pin
    input wire logic OSC_OUT_PIN_I,
    output logic OSC_OUT_PIN_O,
    output logic OSC_OUT_PIN_OE,

    // Port logic drive for the pins when they are general I/O
    input wire logic GPIO_IN_PIN_O,
    input wire logic GPIO_IN_PIN_OE,
    input wire logic GPIO_OUT_PIN_O,
    input wire logic GPIO_OUT_PIN_OE,

    // Pin ownership and read back for the port logic
    output logic IN_PIN_IS_GPIO,
    output logic OUT_PIN_IS_GPIO,
    output logic GPIO_IN_PIN_I,
    output logic GPIO_OUT_PIN_I
);
    // Registered state and its next value
    cmd_pkg::cmd_core_t st_r;
    cmd_pkg::cmd_core_t st_nxt;

    // Decoded mode from the latched origin field
    cmd_pkg::cmd_mode_t mode;

    // Raw oscillator ticks and the selected one
    logic tick_fast;
    logic tick_slow;
    logic base_tick;

    // Divided internal tick and the ratio in force
    logic int_en;
    logic [1:0] sel_used;

    // Mode class flags
    logic is_internal;
    logic is_rc;
    logic is_xtal;
    logic quarter_out;
    logic in_gpio;
    logic out_gpio;

    // Clock edge seen on the input pin
    logic pin_rise;

    // Next system enable and quarter clock level
    logic sys_next;
    logic [1:0] qcnt_next;

    // High range oscillator
    cmd_tickgen #(
        .INC(`CMD_FAST_INC),
        .MOD(`CMD_FAST_MOD)
    ) u_fast_osc (
        .clk(CLK),
        .reset(RESET),
        .tick(tick_fast)
    );

    // Low range oscillator
    cmd_tickgen #(
        .INC(`CMD_SLOW_INC),
        .MOD(`CMD_SLOW_MOD)
    ) u_slow_osc (
        .clk(CLK),
        .reset(RESET),
        .tick(tick_slow)
    );

    // The fixed range picks the divider input
    assign base_tick = st_r.fast ? tick_fast : tick_slow;

    // Postscaler on the chosen oscillator
    cmd_postscale u_post (
        .clk(CLK),
        .reset(RESET),
        .tick(base_tick),
        .sel_req(st_r.sel),
        .div_en(int_en),
        .sel_used(sel_used)
    );

    // Origin field to one of eight modes
    always_comb begin
        case (st_r.origin)
            `CMD_ORG_LP: mode = cmd_pkg::MODE_LOW_POWER_XTAL;
            `CMD_ORG_XT: mode = cmd_pkg::MODE_MEDIUM_XTAL;
            `CMD_ORG_HS: mode = cmd_pkg::MODE_HIGH_XTAL;
            `CMD_ORG_EC: mode = cmd_pkg::MODE_OUTSIDE_CLK;
            `CMD_ORG_INTIO: mode = cmd_pkg::MODE_INT_ALL_IO;
            `CMD_ORG_INTOUT: mode = cmd_pkg::MODE_INT_QUARTER;
            `CMD_ORG_RESISTOR_CAPACITOR_PIN_IO_MODE: mode = cmd_pkg::MODE_RC_PIN_IO;
            default: mode = cmd_pkg::MODE_RC_QUARTER_CLOCK_OUTPUT;
        endcase
    end

    // Mode classes
    always_comb begin
        is_internal = (mode == cmd_pkg::MODE_INT_ALL_IO) ||
                      (mode == cmd_pkg::MODE_INT_QUARTER);
        is_rc = (mode == cmd_pkg::MODE_RC_PIN_IO) ||
                (mode == cmd_pkg::MODE_RC_QUARTER_CLOCK_OUTPUT);
        is_xtal = (mode == cmd_pkg::MODE_LOW_POWER_XTAL) ||
                  (mode == cmd_pkg::MODE_MEDIUM_XTAL) ||
                  (mode == cmd_pkg::MODE_HIGH_XTAL);
        // Quarter clock leaves on the output pin
        quarter_out = (mode == cmd_pkg::MODE_RC_QUARTER_CLOCK_OUTPUT) ||
                      (mode == cmd_pkg::MODE_INT_QUARTER);
        // Input pin is free only with an internal source
        in_gpio = is_internal;
        // Output pin is free in the I/O variants and outside clock
        out_gpio = (mode == cmd_pkg::MODE_RC_PIN_IO) ||
                   (mode == cmd_pkg::MODE_OUTSIDE_CLK) ||
                   (mode == cmd_pkg::MODE_INT_ALL_IO);
    end

    // Rising edge of the external clock on the input pin
    assign pin_rise = OSC_IN_PIN_I && !st_r.pin_d;

    // System clock from the internal divider or the pin
    assign sys_next = is_internal ? int_en : pin_rise;

    // Quarter clock counter advances on each system clock
    assign qcnt_next = sys_next ? 2'(st_r.qcnt + 2'h1) : st_r.qcnt;

    // Next state of the whole block
    always_comb begin
        st_nxt = st_r;
        st_nxt.pin_d = OSC_IN_PIN_I;
        st_nxt.sys_en = sys_next;
        st_nxt.qcnt = qcnt_next;
        // Software rewrite applies from the next divider boundary
        if (FREQ_WR_EN) begin
            st_nxt.sel = FREQ_WR_DATA;
        end
        // Settling counter runs until the lock point
        if (st_r.lock_cnt < 12'(`CMD_LOCK_CYC)) begin
            st_nxt.lock_cnt = 12'(st_r.lock_cnt + 12'h001);
        end
        st_nxt.stable = (st_r.lock_cnt >= 12'(`CMD_STABLE_CYC));
        st_nxt.locked = (st_r.lock_cnt >= 12'(`CMD_LOCK_CYC));
        // Input pin: port drive when free, else listen only
        if (in_gpio) begin
            st_nxt.in_o = GPIO_IN_PIN_O;
            st_nxt.in_oe = GPIO_IN_PIN_OE;
        end else begin
            st_nxt.in_o = 1'b0;
            st_nxt.in_oe = 1'b0;
        end
        // Output pin: quarter clock, crystal drive or port drive
        if (quarter_out) begin
            st_nxt.out_o = qcnt_next[1];
            st_nxt.out_oe = 1'b1;
        end else if (is_xtal) begin
            // Inverting drive closes the resonator loop
            st_nxt.out_o = !OSC_IN_PIN_I;
            st_nxt.out_oe = 1'b1;
        end else if (out_gpio) begin
            st_nxt.out_o = GPIO_OUT_PIN_O;
            st_nxt.out_oe = GPIO_OUT_PIN_OE;
        end else begin
            st_nxt.out_o = 1'b0;
            st_nxt.out_oe = 1'b0;
        end
        // Reset reloads everything; configuration is taken here only
        if (RESET) begin
            st_nxt = '0;
            // Keep tracking the pin so release makes no false edge
            st_nxt.pin_d = OSC_IN_PIN_I;
            st_nxt.origin = CFG_CLK_ORIGIN;
            st_nxt.fast = CFG_FAST_RANGE;
            st_nxt.sel = `CMD_SEL_RESET;
        end
    end

    // One register for all state
    always_ff @(posedge CLK) begin
        st_r <= st_nxt;
    end

    // Control register image: choice, locked, stable
    always_comb begin
        OSC_CTRL_RD = 8'h00;
        OSC_CTRL_RD[`CMD_REG_SEL_HI:`CMD_REG_SEL_LO] = st_r.sel;
        OSC_CTRL_RD[`CMD_REG_LOCKED] = st_r.locked;
        OSC_CTRL_RD[`CMD_REG_STABLE] = st_r.stable;
    end

    // Remaining outputs
    assign CLK_MODE = st_r.origin;
    assign SYS_CLK_EN = st_r.sys_en;
    assign OSC_IN_PIN_O = st_r.in_o;
    assign OSC_IN_PIN_OE = st_r.in_oe;
    assign OSC_OUT_PIN_O = st_r.out_o;
    assign OSC_OUT_PIN_OE = st_r.out_oe;
    assign IN_PIN_IS_GPIO = in_gpio;
    assign OUT_PIN_IS_GPIO = out_gpio;
    assign GPIO_IN_PIN_I = OSC_IN_PIN_I;
    assign GPIO_OUT_PIN_I = OSC_OUT_PIN_I;

    // Checks below share one clock and reset
    default clocking cb @(posedge CLK);
    endclocking
    default disable iff (RESET);

    // Reset release shows the default choice
    sequence rel_s;
        $past(RESET) && !RESET;
    endsequence

    // After reset the choice reads 10
    reset_choice_a: assert property (
        rel_s |-> OSC_CTRL_RD[5:4] == 2'h2)
        else $error("choice not 10 after reset");

    // Range bit never moves outside reset
    range_fixed_a: assert property (
        !$past(RESET) |-> $stable(st_r.fast))
        else $error("range bit changed at run time");

    // Fast range feeds the divider a tick at least every 13 cycles
    range_source_a: assert property (
        st_r.fast && base_tick |-> ##[1:13] base_tick)
        else $error("wrong oscillator feeds divider");

    // A write shows in the register on the next cycle
    write_visible_a: assert property (
        FREQ_WR_EN |=> OSC_CTRL_RD[5:4] == $past(FREQ_WR_DATA))
        else $error("written choice not shown");

    // Locked waits for the settling count
    lock_wait_a: assert property (
        st_r.lock_cnt < 12'(`CMD_LOCK_CYC) |=> !st_r.locked)
        else $error("locked before settling");

    // Unused register bits read zero
    reg_layout_a: assert property (
        OSC_CTRL_RD[7:6] == 2'h0 && OSC_CTRL_RD[1:0] == 2'h0)
        else $error("reserved bits not zero");

    // Quarter clock rises after the second system clock
    sequence two_ticks_s;
        sys_next && st_r.qcnt == 2'h1;
    endsequence
    quarter_rise_a: assert property (
        (two_ticks_s and quarter_out) |=> OSC_OUT_PIN_O && OSC_OUT_PIN_OE)
        else $error("quarter clock did not rise");

    // Free output pin enable follows the port drive enable
    out_io_a: assert property (
        out_gpio && !$past(RESET) |=>
            OSC_OUT_PIN_OE == $past(GPIO_OUT_PIN_OE))
        else $error("output pin not released to port");

    // Outside clock edge becomes a system clock
    ext_edge_a: assert property (
        mode == cmd_pkg::MODE_OUTSIDE_CLK && pin_rise |=> SYS_CLK_EN)
        else $error("outside clock edge lost");

    // Internal modes release the input pin
    in_io_a: assert property (
        is_internal |=> OSC_IN_PIN_OE == $past(GPIO_IN_PIN_OE))
        else $error("input pin not released to port");
endmodule
`default_nettype wire

// File: cmd_clock_ctrl_tb.sv
// Self-checking testbench for the clock mode and divider block
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin \
    compares++; \
    if ((a) !== (e)) begin \
        n_mismatch++; \
        $display("[ERR] t=%0t got %0h exp %0h", $time, (a), (e)); \
    end \
end

module cmd_clock_ctrl_tb;
    // Modes with general I/O input pin, output pin, quarter clock
    localparam logic [7:0] IN_G = 8'h30;
    localparam logic [7:0] OUT_G = 8'h58;
    localparam logic [7:0] QTR = 8'hA0;
    // Internally clocked modes and crystal modes
    localparam logic [7:0] INTL = 8'h30;
    localparam logic [7:0] XTAL = 8'h07;

    // Clock, reset and programmed configuration
    logic clk = 1'b0;
    logic reset = 1'b1;
    logic [2:0] cfg_origin = 3'h5;
    logic cfg_fast = 1'b1;
    // Divider choice write
    logic wr_en = 1'b0;
    logic [1:0] wr_data = 2'h0;
    // Pin levels and port logic drive
    logic osc_in_i = 1'b0;
    logic osc_out_i = 1'b0;
    logic gio_in_o = 1'b0;
    logic gio_in_oe = 1'b0;
    logic gio_out_o = 1'b0;
    logic gio_out_oe = 1'b0;
    // External clock generator control
    logic ext_run = 1'b0;
    int ext_ph = 0;
    // Design outputs
    logic [7:0] rd;
    logic [2:0] clk_mode;
    logic sys_en;
    logic osc_in_o, osc_in_oe, osc_out_o, osc_out_oe;
    logic in_gpio, out_gpio, gpio_in_i, gpio_out_i;
    // Result counters
    int n_mismatch = 0;
    int compares = 0;

    cmd_clock_ctrl cmd_clock_ctrl_inst (
        .CLK(clk), .RESET(reset),
        .CFG_CLK_ORIGIN(cfg_origin), .CFG_FAST_RANGE(cfg_fast),
        .FREQ_WR_EN(wr_en), .FREQ_WR_DATA(wr_data),
        .OSC_CTRL_RD(rd), .CLK_MODE(clk_mode), .SYS_CLK_EN(sys_en),
        .OSC_IN_PIN_I(osc_in_i), .OSC_IN_PIN_O(osc_in_o),
        .OSC_IN_PIN_OE(osc_in_oe), .OSC_OUT_PIN_I(osc_out_i),
        .OSC_OUT_PIN_O(osc_out_o), .OSC_OUT_PIN_OE(osc_out_oe),
        .GPIO_IN_PIN_O(gio_in_o), .GPIO_IN_PIN_OE(gio_in_oe),
        .GPIO_OUT_PIN_O(gio_out_o), .GPIO_OUT_PIN_OE(gio_out_oe),
        .IN_PIN_IS_GPIO(in_gpio), .OUT_PIN_IS_GPIO(out_gpio),
        .GPIO_IN_PIN_I(gpio_in_i), .GPIO_OUT_PIN_I(gpio_out_i)
    );

    // 200 MHz clock
    always #2.5 clk = ~clk;

    // Outside clock on the input pin, one rising edge every 10 cycles
    always begin
        @(posedge clk);
        #1;
        if (ext_run) begin
            ext_ph++;
            if (ext_ph == 5) begin
                ext_ph = 0;
                osc_in_i = ~osc_in_i;
            end
        end
    end

    // Prints the verdict and ends the run
    task automatic finish_test();
        if (n_mismatch == 0 && compares > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    // One clock, then let the edge's updates settle
    task automatic step();
        @(posedge clk);
        #2;
    endtask

    // Reset for 12 cycles with a write attempt that must be ignored
    task automatic do_reset(input logic [2:0] o, input logic f);
        @(posedge clk);
        #1;
        reset = 1'b1;
        cfg_origin = o;
        cfg_fast = f;
        ext_run = 1'b0;
        repeat (6) @(posedge clk);
        #1 wr_en = 1'b1;
        wr_data = 2'h3;
        @(posedge clk);
        #1 wr_en = 1'b0;
        repeat (5) @(posedge clk);
        #1 reset = 1'b0;
    endtask

    // Single write of the divider choice, read back a cycle later
    task automatic write_sel(input logic [1:0] d);
        @(posedge clk);
        #1 wr_en = 1'b1;
        wr_data = d;
        @(posedge clk);
        #1 wr_en = 1'b0;
        `CHK(rd[5:4], d)
    endtask

    // Span of n system clocks and quarter clock toggles within it
    task automatic measure(input int n, input int exp_cyc,
                           input int exp_tog);
        int cyc, tog, seen, lim;
        logic prev;
        cyc = 0;
        tog = 0;
        seen = 0;
        lim = 0;
        do begin
            step();
            lim++;
        end while (sys_en !== 1'b1 && lim < 40000);
        prev = osc_out_o;
        while (seen < n && lim < 40000) begin
            step();
            cyc++;
            lim++;
            if (osc_out_o !== prev) tog++;
            prev = osc_out_o;
            if (sys_en === 1'b1) seen++;
        end
        if (exp_cyc >= 0) `CHK(cyc, exp_cyc)
        if (exp_tog >= 0) `CHK(tog, exp_tog)
    endtask

    // Watchdog against a hang
    initial begin
        #400000;
        n_mismatch++;
        finish_test();
    end

    // Main test sequence
    initial begin
        do_reset(3'h5, 1'b1);
        `CHK(clk_mode, 3'h5)
        `CHK(rd, 8'h20)
        cfg_origin = 3'h0;
        cfg_fast = 1'b0;
        repeat (150) step();
        `CHK(rd, 8'h20)
        repeat (150) step();
        `CHK(rd, 8'h24)
        repeat (150) step();
        `CHK(rd, 8'h2C)
        `CHK(clk_mode, 3'h5)
        measure(8, 200, 4);
        for (int s = 3; s >= 0; s--) begin
            write_sel(s[1:0]);
            measure(2, -1, -1);
            measure(8, 100 << (3 - s), 4);
        end
        // Back to back writes, the last one wins
        @(posedge clk);
        #1 wr_en = 1'b1;
        wr_data = 2'h3;
        @(posedge clk);
        #1 wr_data = 2'h1;
        @(posedge clk);
        #1 wr_en = 1'b0;
        `CHK(rd[5:4], 2'h1)
        measure(2, -1, -1);
        measure(8, 400, 4);
        // Second reset in mid-run, slow set
        do_reset(3'h5, 1'b0);
        `CHK(rd, 8'h20)
        measure(2, 1600, 1);
        // Every clock mode: pin ownership, clock source, pin drive
        for (int o = 0; o < 8; o++) begin
            do_reset(o[2:0], 1'b1);
            ext_run = !INTL[o];
            `CHK(clk_mode, o[2:0])
            `CHK(in_gpio, IN_G[o])
            `CHK(out_gpio, OUT_G[o])
            measure(4, INTL[o] ? 100 : 40,
                    XTAL[o] ? -1 : (QTR[o] ? 2 : 0));
            for (int v = 0; v < 2; v++) begin
                @(posedge clk);
                #1;
                gio_in_o = v[0];
                gio_in_oe = ~v[0];
                gio_out_o = v[0];
                gio_out_oe = ~v[0];
                osc_out_i = v[0];
                if (!ext_run) osc_in_i = v[0];
                step();
                step();
                if (IN_G[o]) begin
                    `CHK(osc_in_o, v[0])
                    `CHK(osc_in_oe, ~v[0])
                    `CHK(gpio_in_i, v[0])
                end else begin
                    `CHK(osc_in_oe, 1'b0)
                end
                if (OUT_G[o]) begin
                    `CHK(osc_out_o, v[0])
                    `CHK(osc_out_oe, ~v[0])
                    `CHK(gpio_out_i, v[0])
                end else begin
                    `CHK(osc_out_oe, 1'b1)
                end
            end
        end
        finish_test();
    end
endmodule
`default_nettype wire
